// file: verilog/chgov_params.svh
// Constants of the changeover fault controller: timing and register map.
// Assumes a 20 MHz pclk; every time below is in the unit its name gives.
`ifndef CHGOV_PARAMS_SVH
`define CHGOV_PARAMS_SVH

// ==========================================================================
// Timing
`define CHGOV_CLK_NS      50
`define CHGOV_MS_NS       1000000
`define CHGOV_RELAY_NS    2000000
`define CHGOV_SLOW_MS     40
`define CHGOV_HOLD_MS     1000
`define CHGOV_BLINK_MS    250
`define CHGOV_SEC_MS      1000
`define CHGOV_AUTOLOCK_S  60
`define CHGOV_DLY0_S      10
`define CHGOV_DLY1_S      70
`define CHGOV_DLY2_S      130
`define CHGOV_DLY3_S      280

// ==========================================================================
// Channel count: ch1..ch11 at index 0..10, timecode 1..3 at 11..13
`define CHGOV_NCH         14

// ==========================================================================
// Register offsets
`define CHGOV_CMD_OFS     8'h00
`define CHGOV_CFG0_OFS    8'h04
`define CHGOV_CFG1_OFS    8'h08
`define CHGOV_STAT_OFS    8'h0C
`define CHGOV_FLT_OFS     8'h10
`define CHGOV_ALM_OFS     8'h14

// ==========================================================================
// Command bits, configuration fields and reset values
`define CHGOV_CMD_PRI     0
`define CHGOV_CMD_BAK     1
`define CHGOV_CMD_AON     2
`define CHGOV_CMD_AOFF    3
`define CHGOV_CMD_CLR     4
`define CHGOV_CFG0_ALM    9
`define CHGOV_CFG0_DLY    10
`define CHGOV_CFG0_RST    32'h0000_0BFF
`define CHGOV_CFG1_RST    32'h0000_0000
`define CHGOV_THR_LOW     2'h0
`define CHGOV_THR_HIGH    2'h1
`define CHGOV_THR_USER    2'h2

`endif

// file: verilog/chgov_pkg.sv
// Types shared by the changeover fault controller.
// Assumes nothing beyond a SystemVerilog package compile.
package chgov_pkg;

  // ========================================================================
  // Panel key lock state
  typedef enum logic [1:0] {
    CHGOV_LK_OPEN = 2'b01,
    CHGOV_LK_SHUT = 2'b10
  } chgov_lock_type;

endpackage

// file: verilog/chgov_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent slow level; no bus coherency.
module chgov_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // ========================================================================
  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // chgov_sync

// file: verilog/chgov_ctrl.sv
// Changeover fault controller: detection, source select, lamps and APB.
// Assumes detector, key, remote and switch pins asynchronous to pclk.
//
// Summary of operation
// - Ch1, ch2, timecode switch within 70 ms.
// - Ch3-8 switch within 1.5H fast, 60 ms slow.
// - Ch9-10 switch within 6 us fast, 60 ms slow.
// - Ch11 switches within 60 us fast, 60 ms slow.
// - Electronic path follows select within 100 ns.
// - Relay output unstable for 2 ms after toggle.
// - Lamp shows faulty system, primary or backup.
// - Per-channel lamp shows the faulty channel.
// - Fast mode: dropout declares fault at once.
// - Slow mode: level below threshold declares fault.
// - Threshold low, high or user per channel.
// - Detection inhibited for selected power-up delay.
// - Timecode lamp is OR of timecode 1..3 on both systems.
// - Alarms for outputs ch3-11 and power supplies.
// - Alarm setting off mutes only output alarms.
// - Held lock key toggles lock; locked ignores other keys.
// - Auto-lock after 60 s without key presses.
// - Remote port: select, auto, reset in; select, fault out.
// - One shared source select, panel key toggles.
// - Auto mode switches on fault; disabled never does.
// - Blink lamp flashes on faults; reset clears latched indications.
// - Local uses panel switches, remote uses network.
`include "chgov_params.svh"
module chgov_ctrl #(
  parameter int MS_CYC    = `CHGOV_MS_NS / `CHGOV_CLK_NS,
  parameter int RELAY_CYC =
    (`CHGOV_RELAY_NS + `CHGOV_CLK_NS - 1) / `CHGOV_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [13:0] pri_drop,
  input  wire logic [13:0] pri_low,
  input  wire logic [13:0] bak_drop,
  input  wire logic [13:0] bak_low,
  input  wire logic [8:0]  out_alarm,
  input  wire logic [1:0]  psu_alarm,
  input  wire logic        key_src,
  input  wire logic        key_auto,
  input  wire logic        key_reset,
  input  wire logic        key_ctrl,
  input  wire logic        key_lock,
  input  wire logic        rem_src,
  input  wire logic        rem_auto,
  input  wire logic        rem_reset,
  input  wire logic [8:0]  dip_fast,
  input  wire logic        dip_alarm_en,
  input  wire logic [1:0]  dip_delay,
  input  wire logic [27:0] dip_thr,
  output logic             path_sel,
  output logic             relay_drive,
  output logic             relay_stable,
  output logic      [27:0] thr_sel,
  output logic             pri_fault_led,
  output logic             bak_fault_led,
  output logic      [13:0] ch_fault_led,
  output logic             tc_fault_led,
  output logic             fault_blink_lamp,
  output logic      [10:0] alarm_led,
  output logic             auto_led,
  output logic             remote_led,
  output logic             lock_led,
  output logic             rem_src_out,
  output logic             rem_fault_out
);

  localparam int SW  = 115;
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int RLW = $clog2(RELAY_CYC + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);
  localparam logic [RLW-1:0] RL_LOAD = RLW'(RELAY_CYC);
  localparam logic [5:0]  SLOW_T = 6'(`CHGOV_SLOW_MS);
  localparam logic [9:0]  HOLD_T = 10'(`CHGOV_HOLD_MS - 1);
  localparam logic [9:0]  SEC_T  = 10'(`CHGOV_SEC_MS - 1);
  localparam logic [7:0]  BLK_T  = 8'(`CHGOV_BLINK_MS - 1);
  localparam logic [5:0]  IDLE_T = 6'(`CHGOV_AUTOLOCK_S - 1);

  // ========================================================================
  // Pin synchronisation
  logic [SW-1:0] syn;
  logic [13:0]   s_pri_drop, s_pri_low, s_bak_drop, s_bak_low;
  logic [8:0]    s_out_alarm, s_dip_fast;
  logic [1:0]    s_psu, s_dip_delay;
  logic [4:0]    s_keys;
  logic [2:0]    s_rem;
  logic          s_dip_alm;
  logic [27:0]   s_dip_thr;

  chgov_sync #(.W(SW)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pri_drop, pri_low, bak_drop, bak_low, out_alarm,
                psu_alarm, key_src, key_auto, key_reset, key_ctrl,
                key_lock, rem_src, rem_auto, rem_reset, dip_fast,
                dip_alarm_en, dip_delay, dip_thr}),
    .sync_out (syn)
  );

  assign {s_pri_drop, s_pri_low, s_bak_drop, s_bak_low, s_out_alarm,
          s_psu, s_keys, s_rem, s_dip_fast, s_dip_alm, s_dip_delay,
          s_dip_thr} = syn;

  // ========================================================================
  // Time base: a 1 ms enable and a 1 s enable
  logic [MSW-1:0] ms_cnt_ff;
  logic [9:0]     sub_ff;
  logic           ms_tick, sec_tick;

  assign ms_tick  = (ms_cnt_ff == MS_LAST);
  assign sec_tick = ms_tick && (sub_ff == SEC_T);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff <= '0;
      sub_ff    <= '0;
    end else begin
      ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 1'b1;
      if (ms_tick) begin
        sub_ff <= sec_tick ? 10'h000 : sub_ff + 10'h001;
      end
    end
  end

  // ========================================================================
  // Configuration source and APB decode
  logic        remote_ff;
  logic [31:0] cfg0_ff, cfg1_ff;
  logic [8:0]  fast_eff;
  logic        alm_en;
  logic [1:0]  dly_eff;
  logic [27:0] thr_eff;
  logic        wr_en, cmd_wr, net_cmd;

  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a == `CHGOV_CMD_OFS)  || (a == `CHGOV_CFG0_OFS) ||
             (a == `CHGOV_CFG1_OFS) || (a == `CHGOV_STAT_OFS) ||
             (a == `CHGOV_FLT_OFS)  || (a == `CHGOV_ALM_OFS);
  endfunction

  // Switch settings are live; only the network copy needs a write.
  assign fast_eff = remote_ff ? cfg0_ff[8:0] : s_dip_fast;
  assign alm_en   = remote_ff ? cfg0_ff[`CHGOV_CFG0_ALM] : s_dip_alm;
  assign dly_eff  = remote_ff ? cfg0_ff[11:10] : s_dip_delay;
  assign thr_eff  = remote_ff ? cfg1_ff[27:0] : s_dip_thr;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !map_ok(paddr);
  assign wr_en   = psel && penable && pwrite && map_ok(paddr);
  assign cmd_wr  = wr_en && (paddr == `CHGOV_CMD_OFS);
  assign net_cmd = cmd_wr && remote_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_ff <= `CHGOV_CFG0_RST;
      cfg1_ff <= `CHGOV_CFG1_RST;
    end else if (wr_en && paddr == `CHGOV_CFG0_OFS) begin
      cfg0_ff <= {20'h0_0000, pwdata[11:0]};
    end else if (wr_en && paddr == `CHGOV_CFG1_OFS) begin
      cfg1_ff <= {4'h0, pwdata[27:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_sel <= '0;
    end else begin
      thr_sel <= thr_eff;
    end
  end

  // ========================================================================
  // Power-up detection inhibit
  logic [8:0] up_sec_ff;
  logic       inhibit_ff;

  function automatic logic [8:0] dly_sec(input logic [1:0] s);
    unique case (s)
      2'h0:    dly_sec = 9'(`CHGOV_DLY0_S);
      2'h1:    dly_sec = 9'(`CHGOV_DLY1_S);
      2'h2:    dly_sec = 9'(`CHGOV_DLY2_S);
      default: dly_sec = 9'(`CHGOV_DLY3_S);
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_sec_ff  <= '0;
      inhibit_ff <= 1'b1;
    end else if (inhibit_ff) begin
      if (up_sec_ff >= dly_sec(dly_eff)) begin
        inhibit_ff <= 1'b0;
      end else if (sec_tick) begin
        up_sec_ff <= up_sec_ff + 9'h001;
      end
    end
  end

  // ========================================================================
  // Fault detection: index 0..13 primary, 14..27 backup
  logic [13:0] fast14;
  logic [27:0] det;
  logic [5:0]  cnt_ff [28];
  logic [RLW-1:0] relay_cnt_ff;

  assign fast14       = {3'h0, fast_eff, 2'h0};
  assign relay_stable = (relay_cnt_ff == '0);

  for (genvar i = 0; i < 28; i++) begin : g_det
    localparam int CH = i % 14;
    logic raw, mask;
    assign raw  = (i < 14)
                ? (fast14[CH] ? s_pri_drop[CH] : s_pri_low[CH])
                : (fast14[CH] ? s_bak_drop[CH] : s_bak_low[CH]);
    // Relay contacts bounce; ch1 and ch2 are judged only once settled.
    assign mask = (CH < 2) && !relay_stable;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_ff[i] <= '0;
      end else if (!raw || inhibit_ff || mask) begin
        cnt_ff[i] <= '0;
      end else if (ms_tick && cnt_ff[i] != SLOW_T) begin
        cnt_ff[i] <= cnt_ff[i] + 6'h01;
      end
    end
    assign det[i] = raw && !inhibit_ff && !mask &&
                    (fast14[CH] || cnt_ff[i] == SLOW_T);
  end

  // ========================================================================
  // Panel keys and key lock
  chgov_pkg::chgov_lock_type lock_ff;
  logic [4:0] keys_q_ff, press;
  logic [3:0] pk;
  logic [9:0] hold_ff;
  logic [5:0] idle_ff;
  logic       key_act, lock_tgl, auto_lock;

  // Key bits: 4 source, 3 auto, 2 reset, 1 control, 0 lock.
  assign press    = s_keys & ~keys_q_ff;
  assign key_act  = |press;
  assign pk       = press[4:1] &
                    {4{lock_ff == chgov_pkg::CHGOV_LK_OPEN}};
  assign lock_tgl = s_keys[0] && ms_tick && (hold_ff == HOLD_T);
  assign auto_lock = sec_tick && !key_act &&
                     (idle_ff == IDLE_T);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_q_ff <= '0;
      hold_ff   <= '0;
    end else begin
      keys_q_ff <= s_keys;
      if (!s_keys[0]) begin
        hold_ff <= '0;
      end else if (ms_tick && hold_ff != 10'h3FF) begin
        hold_ff <= hold_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_ff <= '0;
    end else if (key_act || lock_ff == chgov_pkg::CHGOV_LK_SHUT) begin
      idle_ff <= '0;
    end else if (sec_tick) begin
      idle_ff <= (idle_ff == IDLE_T) ? '0 : idle_ff + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff <= chgov_pkg::CHGOV_LK_OPEN;
    end else begin
      unique case (lock_ff)
        chgov_pkg::CHGOV_LK_OPEN: begin
          if (lock_tgl || auto_lock) begin
            lock_ff <= chgov_pkg::CHGOV_LK_SHUT;
          end
        end
        chgov_pkg::CHGOV_LK_SHUT: begin
          if (lock_tgl) begin
            lock_ff <= chgov_pkg::CHGOV_LK_OPEN;
          end
        end
        default: lock_ff <= chgov_pkg::CHGOV_LK_OPEN;
      endcase
    end
  end

  // ========================================================================
  // Source selection, changeover mode and control location
  logic [2:0] rem_q_ff;
  logic       sel_ff, auto_en_ff;
  logic       man_bak, man_pri, auto_trip, do_clr, nxt_sel;

  assign man_bak = (pk[3] && !sel_ff) ||
                   (s_rem[2] && !rem_q_ff[2]) ||
                   (net_cmd && pwdata[`CHGOV_CMD_BAK]);
  assign man_pri = (pk[3] && sel_ff) ||
                   (!s_rem[2] && rem_q_ff[2]) ||
                   (net_cmd && pwdata[`CHGOV_CMD_PRI]);
  assign auto_trip = auto_en_ff && !sel_ff && (|det[13:0]);
  // A trip outranks a return to primary; backup is then held.
  assign nxt_sel = (auto_trip || man_bak) ? 1'b1
                 : man_pri ? 1'b0 : sel_ff;
  assign do_clr  = pk[1] || (s_rem[0] && !rem_q_ff[0]) ||
                   (cmd_wr && pwdata[`CHGOV_CMD_CLR]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q_ff <= '0;
      sel_ff   <= 1'b0;
    end else begin
      rem_q_ff <= s_rem;
      sel_ff   <= nxt_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_en_ff <= 1'b1;
    end else if (pk[2]) begin
      auto_en_ff <= !auto_en_ff;
    end else if (s_rem[1] != rem_q_ff[1]) begin
      auto_en_ff <= s_rem[1];
    end else if (net_cmd && pwdata[`CHGOV_CMD_AON]) begin
      auto_en_ff <= 1'b1;
    end else if (net_cmd && pwdata[`CHGOV_CMD_AOFF]) begin
      auto_en_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_ff <= 1'b0;
    end else if (pk[0]) begin
      remote_ff <= !remote_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_cnt_ff <= '0;
    end else if (nxt_sel != sel_ff) begin
      relay_cnt_ff <= RL_LOAD;
    end else if (relay_cnt_ff != '0) begin
      relay_cnt_ff <= relay_cnt_ff - 1'b1;
    end
  end

  // ========================================================================
  // Latched faults and alarms; a new event outranks a clear
  logic [13:0] pri_flt_ff, bak_flt_ff;
  logic [10:0] alm_ff, alm_set;

  assign alm_set = {s_psu, s_out_alarm & {9{alm_en}}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_flt_ff <= '0;
      bak_flt_ff <= '0;
      alm_ff     <= '0;
    end else begin
      pri_flt_ff <= (pri_flt_ff & {14{!do_clr}}) | det[13:0];
      bak_flt_ff <= (bak_flt_ff & {14{!do_clr}}) | det[27:14];
      alm_ff     <= (alm_ff & {11{!do_clr}}) | alm_set;
    end
  end

  // ========================================================================
  // Indicators and remote outputs
  logic [7:0] blk_cnt_ff;
  logic       blink_ff, any_flt;

  assign any_flt = |{pri_flt_ff, bak_flt_ff};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_cnt_ff <= '0;
      blink_ff   <= 1'b0;
    end else if (ms_tick) begin
      blk_cnt_ff <= (blk_cnt_ff == BLK_T) ? '0 : blk_cnt_ff + 8'h01;
      if (blk_cnt_ff == BLK_T) begin
        blink_ff <= !blink_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_fault_led    <= 1'b0;
      bak_fault_led    <= 1'b0;
      ch_fault_led     <= '0;
      tc_fault_led     <= 1'b0;
      fault_blink_lamp <= 1'b0;
      alarm_led        <= '0;
      rem_fault_out    <= 1'b0;
    end else begin
      pri_fault_led    <= |pri_flt_ff;
      bak_fault_led    <= |bak_flt_ff;
      ch_fault_led     <= pri_flt_ff | bak_flt_ff;
      tc_fault_led     <= |(pri_flt_ff[13:11] | bak_flt_ff[13:11]);
      fault_blink_lamp <= any_flt && blink_ff;
      alarm_led        <= alm_ff;
      rem_fault_out    <= any_flt;
    end
  end

  assign path_sel    = sel_ff;
  assign relay_drive = sel_ff;
  assign rem_src_out = sel_ff;
  assign auto_led    = auto_en_ff;
  assign remote_led  = remote_ff;
  assign lock_led    = (lock_ff == chgov_pkg::CHGOV_LK_SHUT);

  // ========================================================================
  // APB read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      unique case (paddr)
        `CHGOV_CFG0_OFS: prdata <= cfg0_ff;
        `CHGOV_CFG1_OFS: prdata <= cfg1_ff;
        `CHGOV_STAT_OFS: prdata <= {26'h000_0000, relay_stable,
                                    inhibit_ff, lock_led, remote_ff,
                                    auto_en_ff, sel_ff};
        `CHGOV_FLT_OFS:  prdata <= {2'h0, bak_flt_ff, 2'h0, pri_flt_ff};
        `CHGOV_ALM_OFS:  prdata <= {21'h00_0000, alm_ff};
        default:         prdata <= '0;
      endcase
    end
  end

  // ========================================================================
  // Checks
  sequence s_swap;
    $changed(sel_ff);
  endsequence
  sequence s_settle;
    !relay_stable [*8];
  endsequence

  property p_relay;
    @(posedge pclk) disable iff (!presetn) s_swap |-> s_settle;
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay settle window too short");

  property p_sel_fast;
    @(posedge pclk) disable iff (!presetn) man_bak |=> path_sel;
  endproperty
  a_sel_fast: assert property (p_sel_fast)
    else $error("path select late");

  property p_auto_trip;
    @(posedge pclk) disable iff (!presetn)
      auto_trip |=> path_sel ##1 (path_sel || $past(man_pri));
  endproperty
  a_auto_trip: assert property (p_auto_trip)
    else $error("auto changeover missing");

  property p_no_auto;
    @(posedge pclk) disable iff (!presetn)
      !auto_en_ff && !man_bak |=> !$rose(sel_ff);
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("switched while auto disabled");

  property p_fast_drop;
    @(posedge pclk) disable iff (!presetn)
      fast_eff[0] && s_pri_drop[2] && !inhibit_ff |=> pri_flt_ff[2];
  endproperty
  a_fast_drop: assert property (p_fast_drop)
    else $error("fast dropout not declared");

  property p_slow_ch1;
    @(posedge pclk) disable iff (!presetn)
      s_pri_low[0] && cnt_ff[0] == SLOW_T && !inhibit_ff &&
      relay_stable && auto_en_ff && !sel_ff |=> sel_ff && pri_flt_ff[0];
  endproperty
  a_slow_ch1: assert property (p_slow_ch1)
    else $error("slow fault did not switch");

  property p_tc_or;
    @(posedge pclk) disable iff (!presetn)
      $rose(|(pri_flt_ff[13:11] | bak_flt_ff[13:11])) |=> tc_fault_led;
  endproperty
  a_tc_or: assert property (p_tc_or)
    else $error("timecode lamp not set");

  property p_alm_mute;
    @(posedge pclk) disable iff (!presetn)
      !alm_en && alm_ff[8:0] == 9'h000 |=> alm_ff[8:0] == 9'h000;
  endproperty
  a_alm_mute: assert property (p_alm_mute)
    else $error("output alarm while muted");

  property p_lock_keys;
    @(posedge pclk) disable iff (!presetn)
      lock_ff == chgov_pkg::CHGOV_LK_SHUT && press[1]
      |=> $stable(remote_ff);
  endproperty
  a_lock_keys: assert property (p_lock_keys)
    else $error("key honoured while locked");

  property p_autolock;
    @(posedge pclk) disable iff (!presetn)
      auto_lock |=> lock_ff == chgov_pkg::CHGOV_LK_SHUT;
  endproperty
  a_autolock: assert property (p_autolock)
    else $error("auto lock missing");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      do_clr && alm_set == '0 && det == '0
      |=> alm_ff == '0 && pri_flt_ff == '0 && bak_flt_ff == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("reset did not clear indications");

endmodule // chgov_ctrl

// file: dv/chgov_panel.sv
// Model of the front-panel keys and the remote contact inputs.
// Assumes the bench calls its tasks; levels change after pclk rises.
module chgov_panel (
  input  wire logic       pclk,
  output logic      [4:0] key,
  output logic      [2:0] rem
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Key order is source, auto, reset, control, lock.
  initial key = 5'h00;
  initial rem = 3'h0;
  // A press is held for n cycles; the gap after it lets the
  // synchroniser see the release before the next press.
  task automatic press(input int k, input int n);
    @(posedge pclk);
    key[k] <= 1'b1;
    repeat (n) @(posedge pclk);
    key[k] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic set_rem(input int k, input logic v);
    @(posedge pclk);
    rem[k] <= v;
    repeat (6) @(posedge pclk);
  endtask
endmodule // chgov_panel

// file: dv/tb_top.sv
// Self-checking bench of the changeover controller over APB and pins.
// Assumes a 4-cycle ms tick, so the 10 s power-up delay is 40000 cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] pri_drop, pri_low, bak_drop, ch_fault_led;
  logic [8:0]  out_alarm;
  logic [1:0]  psu_alarm;
  logic [10:0] alarm_led;
  logic [4:0]  key;
  logic [2:0]  rem;
  logic        dip_alarm_en, path_sel, pri_fault_led, bak_fault_led;
  logic        tc_fault_led, fault_blink_lamp, lock_led;
  logic        rem_src_out, rem_fault_out;
  logic [27:0] thr_sel;
  int          err_total = 0;
  int          cmp_count = 0;
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  chgov_panel panel_u (.pclk, .key, .rem);
  chgov_ctrl #(.MS_CYC(MS), .RELAY_CYC(8)) dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .pri_drop, .pri_low, .bak_drop,
    .bak_low(14'h0000), .out_alarm, .psu_alarm, .key_src(key[0]),
    .key_auto(key[1]), .key_reset(key[2]), .key_ctrl(key[3]),
    .key_lock(key[4]), .rem_src(rem[0]), .rem_auto(rem[1]),
    .rem_reset(rem[2]), .dip_fast(9'h1FF), .dip_alarm_en,
    .dip_delay(2'h0), .dip_thr(28'h000_0000), .path_sel,
    .relay_drive(), .relay_stable(), .thr_sel, .pri_fault_led,
    .bak_fault_led, .ch_fault_led, .tc_fault_led, .fault_blink_lamp,
    .alarm_led, .auto_led(), .remote_led(), .lock_led, .rem_src_out,
    .rem_fault_out);
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The inhibit alone takes 40000 cycles; the rest is short.
  initial begin
    cyc(60000);
    err_total++;
    wrap_up();
  end
  // ==========================================================
  // Test sequence
  initial begin
    {presetn, psel, penable, pwrite, dip_alarm_en} = 5'h00;
    {paddr, pwdata, out_alarm, psu_alarm} = '0;
    {pri_drop, pri_low, bak_drop} = '0;
    cyc(5);
    presetn <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd[4:0], 5'h12);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(err, 1'b1);
    pri_drop[2] <= 1'b1;
    cyc(10);
    chk(path_sel, 1'b0);
    pri_drop[2] <= 1'b0;
    repeat (50) begin
      apb(1'b0, 8'h0C, 32'h0000_0000);
      if (rd[4] === 1'b0) break;
      cyc(1000);
    end
    chk(rd[4], 1'b0);
    pri_drop[2] <= 1'b1;
    cyc(5);
    chk(path_sel, 1'b1);
    bak_drop[3] <= 1'b1;
    cyc(5);
    chk({pri_fault_led, bak_fault_led, rem_fault_out}, 3'h7);
    chk(ch_fault_led, 14'h000C);
    {pri_drop, bak_drop} <= '0;
    panel_u.set_rem(2, 1'b1);
    chk({pri_fault_led, rem_fault_out, ch_fault_led}, 0);
    panel_u.set_rem(2, 1'b0);
    chk(path_sel, 1'b1);
    panel_u.press(0, 3);
    chk(path_sel, 1'b0);
    pri_low[11] <= 1'b1;
    cyc(50 * MS);
    chk({tc_fault_led, path_sel}, 2'h3);
    repeat (300 * MS) begin
      if (fault_blink_lamp === 1'b1) break;
      cyc(1);
    end
    chk(fault_blink_lamp, 1'b1);
    pri_low[11] <= 1'b0;
    cyc(5);
    apb(1'b1, 8'h00, 32'h0000_0010);
    cyc(3);
    chk({tc_fault_led, fault_blink_lamp}, 2'h0);
    panel_u.set_rem(0, 1'b1);
    panel_u.set_rem(0, 1'b0);
    chk({path_sel, rem_src_out}, 2'h0);
    out_alarm[0] <= 1'b1;
    psu_alarm[1] <= 1'b1;
    cyc(6);
    chk(alarm_led, 11'h400);
    dip_alarm_en <= 1'b1;
    out_alarm[1] <= 1'b1;
    cyc(6);
    chk(alarm_led[1], 1'b1);
    panel_u.press(3, 3);
    apb(1'b1, 8'h08, 32'h0123_4567);
    apb(1'b1, 8'h00, 32'h0000_0008);
    cyc(2);
    chk(thr_sel, 28'h123_4567);
    pri_drop[4] <= 1'b1;
    cyc(6);
    chk({path_sel, ch_fault_led[4]}, 2'h1);
    pri_drop[4] <= 1'b0;
    panel_u.press(4, 1010 * MS);
    chk(lock_led, 1'b1);
    panel_u.press(0, 3);
    chk(path_sel, 1'b0);
    panel_u.press(3, 3);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd[5:0], 6'h2C);
    wrap_up();
  end
endmodule // tb_top
